// ### common/scpcp_defs.vh
`ifndef SCPCP_DEFS_VH
`define SCPCP_DEFS_VH

// ----------------------------------------
// character codes
// ----------------------------------------
`define SCPCP_CH_LF      8'h0A
`define SCPCP_CH_CR      8'h0D
`define SCPCP_CH_TAB     8'h09
`define SCPCP_CH_SPACE   8'h20
`define SCPCP_CH_STAR    8'h2A
`define SCPCP_CH_COLON   8'h3A
`define SCPCP_CH_SEMI    8'h3B
`define SCPCP_CH_QMARK   8'h3F
`define SCPCP_CASE_BIT   8'h20

// ----------------------------------------
// tree and keyword sizes
// ----------------------------------------
`define SCPCP_NODE_W     6
`define SCPCP_ROOT       6'h00
`define SCPCP_KW_MAX     4'hC
`define SCPCP_KW_BITS    96
`define SCPCP_NUM_NODES  36
`define SCPCP_OPT_DEPTH  2'h2

// ----------------------------------------
// parser states
// ----------------------------------------
`define SCPCP_S_HDR      2'h0
`define SCPCP_S_LOOK     2'h1
`define SCPCP_S_PARAM    2'h2
`define SCPCP_S_SKIP     2'h3

`endif

// ### rtl/scpcp_kw_match.v
`timescale 1ns/1ps
`include "scpcp_defs.vh"

module scpcp_kw_match #(
  parameter NODES = `SCPCP_NUM_NODES
) (
  input  wire [5:0]  parent,
  input  wire [95:0] word,
  input  wire [3:0]  len,
  output reg         hit,
  output reg  [5:0]  hit_id,
  output reg         hit_high,
  output reg         opt_hit,
  output reg  [5:0]  opt_id
);

  // ----------------------------------------
  // keyword table: {parent, opt, high, short len, long len, long form}
  // ----------------------------------------
  function [111:0] ent;
    input [5:0]  par;
    input        opt;
    input        high;
    input [3:0]  sl;
    input [3:0]  ll;
    input [95:0] s;
    begin
      ent = {par, opt, high, sl, ll, s};
    end
  endfunction

  function [111:0] tbl;
    input integer i;
    begin
      case (i)
        1:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h5, "ABORT");
        2:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h3, 4'h9, "CALIBRATE");
        3:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h7, "DISPLAY");
        4:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h4, "LIST");
        5:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h7, "MEASURE");
        6:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h6, "OUTPUT");
        7:  tbl = ent(6'h00, 1'b1, 1'b0, 4'h4, 4'h6, "SOURCE");
        8:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h6, "STATUS");
        9:  tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h7, "STORAGE");
        10: tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h6, "SYSTEM");
        11: tbl = ent(6'h00, 1'b0, 1'b0, 4'h4, 4'h7, "TRIGGER");
        12: tbl = ent(6'h07, 1'b0, 1'b0, 4'h4, 4'h7, "VOLTAGE");
        13: tbl = ent(6'h07, 1'b0, 1'b0, 4'h4, 4'h7, "CURRENT");
        14: tbl = ent(6'h07, 1'b0, 1'b0, 4'h4, 4'h8, "FUNCTION");
        15: tbl = ent(6'h0C, 1'b1, 1'b0, 4'h3, 4'h5, "LEVEL");
        16: tbl = ent(6'h0F, 1'b1, 1'b0, 4'h3, 4'h9, "IMMEDIATE");
        17: tbl = ent(6'h10, 1'b0, 1'b0, 4'h4, 4'h9, "AMPLITUDE");
        18: tbl = ent(6'h0C, 1'b0, 1'b0, 4'h3, 4'h5, "LIMIT");
        19: tbl = ent(6'h12, 1'b0, 1'b1, 4'h4, 4'h4, "HIGH");
        20: tbl = ent(6'h0D, 1'b1, 1'b0, 4'h3, 4'h5, "LEVEL");
        21: tbl = ent(6'h14, 1'b1, 1'b0, 4'h3, 4'h9, "IMMEDIATE");
        22: tbl = ent(6'h15, 1'b0, 1'b0, 4'h4, 4'h9, "AMPLITUDE");
        23: tbl = ent(6'h0D, 1'b0, 1'b0, 4'h3, 4'h5, "LIMIT");
        24: tbl = ent(6'h17, 1'b0, 1'b1, 4'h4, 4'h4, "HIGH");
        25: tbl = ent(6'h08, 1'b0, 1'b0, 4'h4, 4'h9, "OPERATION");
        26: tbl = ent(6'h08, 1'b0, 1'b0, 4'h4, 4'h6, "PRESET");
        27: tbl = ent(6'h08, 1'b0, 1'b0, 4'h4, 4'hC, "QUESTIONABLE");
        28: tbl = ent(6'h19, 1'b0, 1'b0, 4'h4, 4'h9, "CONDITION");
        29: tbl = ent(6'h19, 1'b0, 1'b0, 4'h4, 4'h6, "ENABLE");
        30: tbl = ent(6'h19, 1'b0, 1'b0, 4'h4, 4'h5, "EVENT");
        31: tbl = ent(6'h05, 1'b0, 1'b0, 4'h4, 4'h7, "VOLTAGE");
        32: tbl = ent(6'h05, 1'b0, 1'b0, 4'h4, 4'h7, "CURRENT");
        33: tbl = ent(6'h0E, 1'b0, 1'b0, 4'h4, 4'h4, "MODE");
        34: tbl = ent(6'h0C, 1'b0, 1'b0, 4'h4, 4'hA, "PROTECTION");
        35: tbl = ent(6'h0C, 1'b0, 1'b0, 4'h4, 4'h7, "TRIGGER");
        36: tbl = ent(6'h0C, 1'b0, 1'b0, 4'h4, 4'h4, "MODE");
        default: tbl = 112'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // parallel compare, one lane per node
  // ----------------------------------------
  wire [NODES:1] m_vec;
  wire [NODES:1] o_vec;
  wire [NODES:1] h_vec;

  genvar g;
  generate
    for (g = 1; g <= NODES; g = g + 1) begin : g_node
      wire [111:0] e     = tbl(g);
      wire [95:0]  lng   = e[95:0];
      wire [3:0]   ll    = e[99:96];
      wire [3:0]   sl    = e[103:100];
      wire [95:0]  shrt  = lng >> {ll - sl, 3'h0};
      wire         at_p  = (e[111:106] == parent);
      assign m_vec[g] = at_p && (((len == ll) && (word == lng)) ||
                                 ((len == sl) && (word == shrt)));
      assign o_vec[g] = at_p && e[105];
      assign h_vec[g] = e[104];
    end
  endgenerate

  // ids under one parent never collide, so an or-encoder is enough
  integer k;
  always @* begin
    hit      = 1'b0;
    hit_id   = 6'h00;
    hit_high = 1'b0;
    opt_hit  = 1'b0;
    opt_id   = 6'h00;
    for (k = 1; k <= NODES; k = k + 1) begin
      if (m_vec[k]) begin
        hit      = 1'b1;
        hit_id   = hit_id | k[5:0];
        hit_high = hit_high | h_vec[k];
      end
      if (o_vec[k]) begin
        opt_hit = 1'b1;
        opt_id  = opt_id | k[5:0];
      end
    end
  end

endmodule

// ### rtl/scpcp_parser.v
`timescale 1ns/1ps
`include "scpcp_defs.vh"

module scpcp_parser (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire [7:0] byte_data,
  input  wire       byte_valid,
  output reg        byte_ready,
  input  wire       err_clear,
  output reg        hdr_valid,
  output reg  [5:0] hdr_node,
  output reg        hdr_query,
  output reg        hdr_common,
  output reg        msg_end,
  output reg        syntax_err,
  output reg        err_pending
);

  // ----------------------------------------
  // character helpers
  // ----------------------------------------
  function [7:0] upcase;
    input [7:0] c;
    begin
      if (c >= 8'h61 && c <= 8'h7A)
        upcase = c & ~`SCPCP_CASE_BIT;
      else
        upcase = c;
    end
  endfunction
  function is_kw;
    input [7:0] c;
    begin
      is_kw = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A) ||
              (c >= 8'h30 && c <= 8'h39);
    end
  endfunction
  function is_ws;
    input [7:0] c;
    begin
      is_ws = (c == `SCPCP_CH_SPACE) || (c == `SCPCP_CH_TAB) || (c == `SCPCP_CH_CR);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [1:0]  state_q,    state_d;
  reg [95:0] word_q,     word_d;
  reg [3:0]  len_q,      len_d;
  reg [5:0]  cur_par_q,  cur_par_d;
  reg [5:0]  sib_par_q,  sib_par_d;
  reg [5:0]  unit_par_q, unit_par_d;
  reg [5:0]  try_par_q,  try_par_d;
  reg [5:0]  gp_par_q,   gp_par_d;
  reg [1:0]  tries_q,    tries_d;
  reg [7:0]  sep_q,      sep_d;
  reg        ustart_q,   ustart_d;
  reg        first_q,    first_d;
  reg        semi_q,     semi_d;
  reg        common_q,   common_d;
  reg        rdy_d;
  reg        hv_d;
  reg [5:0]  node_d;
  reg        query_d;
  reg        hcom_d;
  reg        mend_d;
  reg        err_d;
  reg        pend_d;
  reg        fail;
  reg [7:0]  fsep;
  reg        newunit;
  reg        nsemi;
  reg        endmsg;
  wire       hit;
  wire [5:0] hit_id;
  wire       hit_high;
  wire       opt_hit;
  wire [5:0] opt_id;
  scpcp_kw_match #(
    .NODES (`SCPCP_NUM_NODES)
  ) u_match (
    .parent   (try_par_q),
    .word     (word_q),
    .len      (len_q),
    .hit      (hit),
    .hit_id   (hit_id),
    .hit_high (hit_high),
    .opt_hit  (opt_hit),
    .opt_id   (opt_id)
  );
  wire       take = byte_valid && byte_ready;
  wire [7:0] uc   = upcase(byte_data);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_d    = state_q;
    word_d     = word_q;
    len_d      = len_q;
    cur_par_d  = cur_par_q;
    sib_par_d  = sib_par_q;
    unit_par_d = unit_par_q;
    try_par_d  = try_par_q;
    gp_par_d   = gp_par_q;
    tries_d    = tries_q;
    sep_d      = sep_q;
    ustart_d   = ustart_q;
    first_d    = first_q;
    semi_d     = semi_q;
    common_d   = common_q;
    hv_d       = 1'b0;
    node_d     = hdr_node;
    query_d    = hdr_query;
    hcom_d     = hdr_common;
    mend_d     = 1'b0;
    err_d      = 1'b0;
    fail       = 1'b0;
    fsep       = 8'h00;
    newunit    = 1'b0;
    nsemi      = 1'b0;
    endmsg     = 1'b0;
    case (state_q)
      `SCPCP_S_HDR: begin
        if (take) begin
          if (byte_data == `SCPCP_CH_STAR && ustart_q && !common_q) begin
            common_d = 1'b1;
            ustart_d = 1'b0;
          end else if (is_kw(byte_data)) begin
            if (len_q == `SCPCP_KW_MAX) begin
              fail = 1'b1;
            end else begin
              word_d   = {word_q[87:0], uc};
              len_d    = len_q + 4'h1;
              ustart_d = 1'b0;
            end
          end else if (byte_data == `SCPCP_CH_COLON) begin
            if (len_q == 4'h0 && ustart_q) begin
              cur_par_d = `SCPCP_ROOT;
              ustart_d  = 1'b0;
              semi_d    = 1'b0;
            end else if (len_q == 4'h0 || common_q) begin
              fail = 1'b1;
            end else begin
              sep_d     = byte_data;
              try_par_d = cur_par_q;
              tries_d   = 2'h0;
              state_d   = `SCPCP_S_LOOK;
            end
          end else if ((is_ws(byte_data) || byte_data == `SCPCP_CH_SEMI) && ustart_q) begin
            state_d = `SCPCP_S_HDR;
          end else if (byte_data == `SCPCP_CH_LF && len_q == 4'h0 && !common_q) begin
            endmsg = 1'b1;
          end else if (byte_data == `SCPCP_CH_SEMI || byte_data == `SCPCP_CH_LF ||
                       byte_data == `SCPCP_CH_QMARK || is_ws(byte_data)) begin
            if (common_q) begin
              // common headers carry no path and leave the position alone
              hv_d    = 1'b1;
              node_d  = `SCPCP_ROOT;
              hcom_d  = 1'b1;
              query_d = (byte_data == `SCPCP_CH_QMARK);
              if (byte_data == `SCPCP_CH_SEMI) begin
                newunit = 1'b1;
                nsemi   = 1'b1;
              end else if (byte_data == `SCPCP_CH_LF) begin
                endmsg = 1'b1;
              end else begin
                state_d = `SCPCP_S_PARAM;
              end
            end else if (len_q == 4'h0) begin
              fail = 1'b1;
            end else begin
              sep_d     = is_ws(byte_data) ? `SCPCP_CH_SPACE : byte_data;
              try_par_d = cur_par_q;
              tries_d   = 2'h0;
              state_d   = `SCPCP_S_LOOK;
            end
          end else begin
            fail = 1'b1;
          end
          fsep = byte_data;
        end
      end
      `SCPCP_S_LOOK: begin
        fsep = sep_q;
        if (hit) begin
          if (semi_q && first_q && hit_high) begin
            fail = 1'b1;
          end else if (sep_q == `SCPCP_CH_COLON) begin
            cur_par_d = hit_id;
            gp_par_d  = try_par_q;
            first_d   = 1'b0;
            word_d    = 96'h0;
            len_d     = 4'h0;
            state_d   = `SCPCP_S_HDR;
          end else begin
            hv_d      = 1'b1;
            node_d    = hit_id;
            hcom_d    = 1'b0;
            query_d   = (sep_q == `SCPCP_CH_QMARK);
            sib_par_d = hit_high ? gp_par_q : try_par_q;
            if (sep_q == `SCPCP_CH_SEMI) begin
              cur_par_d = try_par_q;
              newunit   = 1'b1;
              nsemi     = 1'b1;
            end else if (sep_q == `SCPCP_CH_LF) begin
              endmsg = 1'b1;
            end else begin
              state_d = `SCPCP_S_PARAM;
            end
          end
        end else if (opt_hit && tries_q < `SCPCP_OPT_DEPTH) begin
          try_par_d = opt_id;
          tries_d   = tries_q + 2'h1;
        end else begin
          fail = 1'b1;
        end
      end
      `SCPCP_S_PARAM, `SCPCP_S_SKIP: begin
        // quoted parameter text holding a semicolon is not recognised
        if (take && byte_data == `SCPCP_CH_SEMI) begin
          cur_par_d = (state_q == `SCPCP_S_PARAM) ? sib_par_q : unit_par_q;
          newunit   = 1'b1;
          nsemi     = 1'b1;
        end else if (take && byte_data == `SCPCP_CH_LF) begin
          endmsg = 1'b1;
        end
      end
      default: begin
        state_d = `SCPCP_S_HDR;
      end
    endcase
    if (fail) begin
      err_d     = 1'b1;
      cur_par_d = unit_par_q;
      if (fsep == `SCPCP_CH_LF) begin
        endmsg = 1'b1;
      end else if (fsep == `SCPCP_CH_SEMI) begin
        newunit = 1'b1;
        nsemi   = 1'b1;
      end else begin
        state_d = `SCPCP_S_SKIP;
      end
    end
    if (endmsg) begin
      mend_d    = 1'b1;
      cur_par_d = `SCPCP_ROOT;
      sib_par_d = `SCPCP_ROOT;
      newunit   = 1'b1;
    end
    if (newunit) begin
      state_d    = `SCPCP_S_HDR;
      word_d     = 96'h0;
      len_d      = 4'h0;
      ustart_d   = 1'b1;
      first_d    = 1'b1;
      common_d   = 1'b0;
      semi_d     = nsemi;
      unit_par_d = cur_par_d;
    end
    // a fresh error beats a clear in the same cycle
    pend_d = (err_pending && !err_clear) || err_d;
    rdy_d  = (state_d != `SCPCP_S_LOOK);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= `SCPCP_S_HDR;
      word_q      <= 96'h0;
      len_q       <= 4'h0;
      cur_par_q   <= `SCPCP_ROOT;
      sib_par_q   <= `SCPCP_ROOT;
      unit_par_q  <= `SCPCP_ROOT;
      try_par_q   <= `SCPCP_ROOT;
      gp_par_q    <= `SCPCP_ROOT;
      tries_q     <= 2'h0;
      sep_q       <= 8'h00;
      ustart_q    <= 1'b1;
      first_q     <= 1'b1;
      semi_q      <= 1'b0;
      common_q    <= 1'b0;
      byte_ready  <= 1'b1;
      hdr_valid   <= 1'b0;
      hdr_node    <= 6'h00;
      hdr_query   <= 1'b0;
      hdr_common  <= 1'b0;
      msg_end     <= 1'b0;
      syntax_err  <= 1'b0;
      err_pending <= 1'b0;
    end else begin
      state_q     <= state_d;
      word_q      <= word_d;
      len_q       <= len_d;
      cur_par_q   <= cur_par_d;
      sib_par_q   <= sib_par_d;
      unit_par_q  <= unit_par_d;
      try_par_q   <= try_par_d;
      gp_par_q    <= gp_par_d;
      tries_q     <= tries_d;
      sep_q       <= sep_d;
      ustart_q    <= ustart_d;
      first_q     <= first_d;
      semi_q      <= semi_d;
      common_q    <= common_d;
      byte_ready  <= rdy_d;
      hdr_valid   <= hv_d;
      hdr_node    <= node_d;
      hdr_query   <= query_d;
      hdr_common  <= hcom_d;
      msg_end     <= mend_d;
      syntax_err  <= err_d;
      err_pending <= pend_d;
    end
  end
endmodule

// ### testbench/scpcp_parser_properties.sv
`timescale 1ns/1ps

module scpcp_parser_props (
  input wire       core_clk,
  input wire       arst_n,
  input wire [7:0] byte_data,
  input wire       byte_valid,
  input wire       byte_ready,
  input wire       err_clear,
  input wire       hdr_valid,
  input wire [5:0] hdr_node,
  input wire       hdr_query,
  input wire       hdr_common,
  input wire       msg_end,
  input wire       syntax_err,
  input wire       err_pending
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire lf_take = byte_valid && byte_ready && (byte_data == 8'h0A);
  wire q_take  = byte_valid && byte_ready && (byte_data == 8'h3F);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_rel_a: assert property ($rose(arst_n) |-> byte_ready && !hdr_valid && !err_pending)
    else $error("outputs wrong after reset release");
  lf_end_a: assert property (lf_take |-> ##[1:4] msg_end)
    else $error("no message end after line feed");
  end_cause_a: assert property (msg_end |-> $past(lf_take, 1) || $past(lf_take, 2)
    || $past(lf_take, 3) || $past(lf_take, 4))
    else $error("message end without line feed");
  err_set_a: assert property (syntax_err |-> err_pending)
    else $error("error not recorded");
  err_clear_a: assert property (err_pending && err_clear |=> err_pending == syntax_err)
    else $error("error not cleared");
  err_hold_a: assert property (err_pending && !err_clear |=> err_pending)
    else $error("error lost without clear");
  common_node_a: assert property (hdr_valid && hdr_common |-> hdr_node == 6'h00)
    else $error("common header carries a tree node");
  drop_bad_a: assert property (!(hdr_valid && syntax_err))
    else $error("rejected header also resolved");
  stall_bound_a: assert property (!byte_ready |-> ##[1:3] byte_ready)
    else $error("byte stall too long");
  query_cause_a: assert property (hdr_valid && hdr_query |-> $past(q_take, 1)
    || $past(q_take, 2) || $past(q_take, 3) || $past(q_take, 4))
    else $error("query flag without question mark");

  query_c: cover property (hdr_valid && hdr_query);
  common_c: cover property (hdr_valid && hdr_common);
  error_c: cover property (syntax_err);
  stall_c: cover property (!byte_ready ##1 !byte_ready);
endmodule

bind scpcp_parser scpcp_parser_props u_props (
  .core_clk    (core_clk),
  .arst_n      (arst_n),
  .byte_data   (byte_data),
  .byte_valid  (byte_valid),
  .byte_ready  (byte_ready),
  .err_clear   (err_clear),
  .hdr_valid   (hdr_valid),
  .hdr_node    (hdr_node),
  .hdr_query   (hdr_query),
  .hdr_common  (hdr_common),
  .msg_end     (msg_end),
  .syntax_err  (syntax_err),
  .err_pending (err_pending)
);

// ### testbench/scpcp_host.sv
`timescale 1ns/1ps

module scpcp_host (
  input  wire       core_clk,
  input  wire       byte_ready,
  output reg  [7:0] byte_data,
  output reg        byte_valid
);
  initial begin
    byte_data = 8'hFF;
    byte_valid = 1'b0;
  end

  // ----------------------------------------
  // byte sender
  // ----------------------------------------
  // idle data is the inverse of the last byte, so stale values never match
  task automatic send_msg(input string s, input bit add_lf);
    int i;
    logic [7:0] c;
    begin
      c = 8'h00;
      @(posedge core_clk);
      for (i = 0; i <= s.len(); i++) begin
        if (i == s.len() && !add_lf) break;
        c = (i == s.len()) ? 8'h0A : s[i];
        byte_data <= c;
        byte_valid <= 1'b1;
        do @(posedge core_clk); while (byte_ready !== 1'b1);
      end
      byte_valid <= 1'b0;
      byte_data <= ~c;
    end
  endtask
endmodule

// ### testbench/test_scpcp_parser.sv
`timescale 1ns/1ps

module test_scpcp_parser;
  typedef struct {string m; int n; logic [8:0] e0; logic [8:0] e1;} scpcp_row_t;

  logic       core_clk;
  logic       arst_n;
  logic       err_clear;
  wire  [7:0] byte_data;
  wire        byte_valid;
  wire        byte_ready;
  wire        hdr_valid;
  wire  [5:0] hdr_node;
  wire        hdr_query;
  wire        hdr_common;
  wire        msg_end;
  wire        syntax_err;
  wire        err_pending;
  int         n_errors;
  int         samples_checked;
  int         n_end;
  int         i;
  int         j;
  logic [8:0] evq[$];
  scpcp_row_t rows[21];
  string      roots[11];
  localparam logic [8:0] ER = 9'h100;

  scpcp_host host (
    .core_clk   (core_clk),
    .byte_ready (byte_ready),
    .byte_data  (byte_data),
    .byte_valid (byte_valid)
  );

  scpcp_parser dut (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .byte_data   (byte_data),
    .byte_valid  (byte_valid),
    .byte_ready  (byte_ready),
    .err_clear   (err_clear),
    .hdr_valid   (hdr_valid),
    .hdr_node    (hdr_node),
    .hdr_query   (hdr_query),
    .hdr_common  (hdr_common),
    .msg_end     (msg_end),
    .syntax_err  (syntax_err),
    .err_pending (err_pending)
  );

  // ----------------------------------------
  // clock, monitor, helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (arst_n === 1'b1 && hdr_valid === 1'b1) evq.push_back({1'b0, hdr_node, hdr_query, hdr_common});
    if (arst_n === 1'b1 && syntax_err === 1'b1) evq.push_back(ER);
    if (arst_n === 1'b1 && msg_end === 1'b1) n_end++;
  end

  function automatic logic [8:0] ev(input logic [5:0] nd, input logic q, input logic c);
    return {1'b0, nd, q, c};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_msg(input string s);
    int k;
    begin
      evq.delete();
      n_end = 0;
      host.send_msg(s, 1'b1);
      k = 0;
      while (n_end == 0 && k < 20) begin
        @(posedge core_clk);
        k++;
      end
      repeat (3) @(posedge core_clk);
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    err_clear = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    n_end = 0;
    rows[0] = '{"STAT?", 1, ev(6'h08, 1'b1, 1'b0), 9'h000};
    rows[1] = '{"STAT:PRES", 1, ev(6'h1A, 1'b0, 1'b0), 9'h000};
    rows[2] = '{"STAT:OPER?;PRES", 2, ev(6'h19, 1'b1, 1'b0), ev(6'h1A, 1'b0, 1'b0)};
    rows[3] = '{"STAT:OPER:COND?;ENAB 16", 2, ev(6'h1C, 1'b1, 1'b0), ev(6'h1D, 1'b0, 1'b0)};
    rows[4] = '{"VOLT 5;CURR 1", 2, ev(6'h0C, 1'b0, 1'b0), ev(6'h0D, 1'b0, 1'b0)};
    rows[5] = '{"meas:volt?;curr?", 2, ev(6'h1F, 1'b1, 1'b0), ev(6'h20, 1'b1, 1'b0)};
    rows[6] = '{"meas:volt?;:curr?", 2, ev(6'h1F, 1'b1, 1'b0), ev(6'h0D, 1'b1, 1'b0)};
    rows[7] = '{":OUTP", 1, ev(6'h06, 1'b0, 1'b0), 9'h000};
    rows[8] = '{"*IDN?", 1, ev(6'h00, 1'b1, 1'b1), 9'h000};
    rows[9] = '{"VOLTAGE:LIM:HIGH?", 1, ev(6'h13, 1'b1, 1'b0), 9'h000};
    rows[10] = '{"VOLT:LIM:HIGH? MIN;high? max", 2, ev(6'h13, 1'b1, 1'b0), ER};
    rows[11] = '{"VOLT:LIM:HIGH? 1;:volt:lim:high? 2", 2, ev(6'h13, 1'b1, 1'b0),
                 ev(6'h13, 1'b1, 1'b0)};
    rows[12] = '{"VOLT:AMPL", 1, ev(6'h11, 1'b0, 1'b0), 9'h000};
    rows[13] = '{"SOURCE:VOLT:LEV:IMM:AMPL", 1, ev(6'h11, 1'b0, 1'b0), 9'h000};
    rows[14] = '{"VOLTA", 1, ER, 9'h000};
    rows[15] = '{"SoUrCe:VoLt", 1, ev(6'h0C, 1'b0, 1'b0), 9'h000};
    rows[16] = '{"STAT:OPER", 1, ev(6'h19, 1'b0, 1'b0), 9'h000};
    rows[17] = '{"PRES", 1, ER, 9'h000};
    rows[18] = '{"LIST;STOR", 2, ev(6'h04, 1'b0, 1'b0), ev(6'h09, 1'b0, 1'b0)};
    rows[19] = '{"*RST;STAT:QUES?", 2, ev(6'h00, 1'b0, 1'b1), ev(6'h1B, 1'b1, 1'b0)};
    rows[20] = '{"VOLT:LIM:HIGH?MIN;lim:high? max", 2, ev(6'h13, 1'b1, 1'b0),
                 ev(6'h13, 1'b1, 1'b0)};
    roots = '{"ABOR", "CAL", "DISP", "LIST", "MEAS", "OUTP", "SOUR", "STAT", "STOR",
              "SYST", "TRIG"};
    repeat (10) @(posedge core_clk);
    chk(16'({byte_ready, hdr_valid, msg_end, syntax_err, err_pending, hdr_node}), 16'h0400);
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    $display("reset test done");
    for (i = 0; i < 21; i++) begin
      run_msg(rows[i].m);
      chk(16'(n_end), 16'h0001);
      chk(16'(evq.size()), 16'(rows[i].n));
      for (j = 0; j < rows[i].n; j++)
        chk(16'(evq[j]), 16'(j == 0 ? rows[i].e0 : rows[i].e1));
      $display("row %0d done", i);
    end
    for (i = 0; i < 11; i++) begin
      run_msg(roots[i]);
      chk(16'(evq.size()), 16'h0001);
      chk(16'(evq[0]), 16'(ev(6'(i + 1), 1'b0, 1'b0)));
    end
    $display("root test done");
    chk(16'(err_pending), 16'h0001);
    @(posedge core_clk);
    err_clear <= 1'b1;
    @(posedge core_clk);
    err_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(16'(err_pending), 16'h0000);
    $display("error clear test done");
    // a reset in mid-message must leave the tree position at the root
    host.send_msg("STAT:OPER", 1'b0);
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    run_msg("PRES");
    chk(16'(evq.size()), 16'h0001);
    chk(16'(evq[0]), 16'(ER));
    $display("mid reset test done");
    report_and_stop();
  end
endmodule
